// ===== hdl/gptu_top.sv
// General purpose timer unit: two modules, five timers, capture/reload register
// Pins are synchronous to core_clk; registers sit on a plain strobe port
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "gptu_map.svh"
module gptu_top #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Timer pins, one bit per timer, plus the single capture pin
  input wire logic [`GPTU_NT-1:0] timer_count_gate_input,
  input wire logic [`GPTU_NT-1:0] timer_direction_input,
  input wire logic capture_input_pin,
  // Timer outputs
  output logic core_toggle_output_pin,
  output logic second_core_toggle_output_pin,
  output logic second_core_wrap_pulse
);
  typedef struct packed {
    logic [`GPTU_NT-1:0][15:0] ctrl;
    logic [15:0] pre1;
    logic [15:0] pre2;
    logic [W-1:0] capreg;
    logic [`GPTU_NFL-1:0] flags;
    logic [`GPTU_NT-1:0] cgi_q;
    logic [`GPTU_NT-1:0] dir_q;
    logic cap_q;
    logic [`GPTU_NT-1:0] pend;
    logic [`GPTU_NT-1:0] pend_dn;
    logic latch1;
    logic latch1_q;
    logic latch2;
    logic latch2_q;
    logic pin1;
    logic pin2;
    logic wrap_p;
    logic [15:0] rdata;
  } gptu_state_t;

  gptu_state_t state_reg;
  gptu_state_t state_next;
  logic [`GPTU_NT-1:0] step;
  logic [`GPTU_NT-1:0] dn;
  logic [`GPTU_NT-1:0] ld;
  logic [`GPTU_NT-1:0] cap;
  logic [`GPTU_NT-1:0] swld;
  logic [W-1:0] ldv [`GPTU_NT];
  logic [W-1:0] val [`GPTU_NT];
  logic [`GPTU_NT-1:0] wrap;
  logic capr;
  logic [`GPTU_NFL-1:0] clr;
  logic [`GPTU_NT-1:0] rld;

  if (W < 8 || W > 16) begin : g_bad_width
    $error("gptu_top width must be 8 to 16");
  end

  function automatic logic edge_hit(logic [1:0] sel, logic now, logic prev);
    edge_hit = (sel[0] & now & ~prev) | (sel[1] & ~now & prev);
  endfunction : edge_hit

  // True once every 2**n cycles of the free-running divider
  function automatic logic tick_at(logic [15:0] cnt, int n);
    logic [15:0] m;
    m = 16'((32'h1 << n) - 32'h1);
    tick_at = ((cnt & m) == m);
  endfunction : tick_at

  for (genvar g = 0; g < `GPTU_NT; g++) begin : g_timer
    gptu_timer #(
      .W(W)
    ) u_timer (
      .core_clk(core_clk),
      .resetn(resetn),
      .step(step[g]),
      .down(dn[g]),
      .load(ld[g]),
      .load_val(ldv[g]),
      .value(val[g]),
      .wrap(wrap[g])
    );
  end

  always_comb begin
    logic [15:0] c;
    gptu_pkg::gptu_mode_t md;
    gptu_pkg::gptu_csrc_t cs;
    logic m1;
    logic base1;
    logic base2;
    logic base;
    logic tick;
    logic pe;
    logic le;
    logic ev;
    logic dnow;
    logic ec;
    logic et;
    logic ed;
    c = '0;
    md = gptu_pkg::M_TIMER;
    cs = gptu_pkg::CS_PIN;
    m1 = 1'b0;
    base = 1'b0;
    tick = 1'b0;
    pe = 1'b0;
    le = 1'b0;
    ev = 1'b0;
    dnow = 1'b0;
    base1 = 1'b0;
    base2 = 1'b0;
    ec = 1'b0;
    et = 1'b0;
    ed = 1'b0;
    state_next = state_reg;
    step = '0;
    dn = '0;
    ld = '0;
    cap = '0;
    swld = '0;
    rld = '0;
    clr = '0;
    for (int i = 0; i < `GPTU_NT; i++) begin
      ldv[i] = '0;
    end
    state_next.pre1 = state_reg.pre1 + 16'h1;
    state_next.pre2 = state_reg.pre2 + 16'h1;
    // First module base step every 4 clocks
    base1 = tick_at(state_reg.pre1, `GPTU_M1_BASE_LOG);
    // Second module base step every 2 clocks
    base2 = tick_at(state_reg.pre2, `GPTU_M2_BASE_LOG);

    for (int i = 0; i < `GPTU_NT; i++) begin
      c = state_reg.ctrl[i];
      md = gptu_pkg::gptu_mode_t'(c[`GPTU_F_MODE]);
      m1 = (i < `GPTU_M1_NT);
      base = m1 ? base1 : base2;
      // Prescaler divides the base rate by 2**sel
      tick = m1 ? tick_at(state_reg.pre1, `GPTU_M1_BASE_LOG + int'(c[`GPTU_F_PRE]))
                : tick_at(state_reg.pre2, `GPTU_M2_BASE_LOG + int'(c[`GPTU_F_PRE]));
      pe = edge_hit(c[`GPTU_F_EDGE], timer_count_gate_input[i], state_reg.cgi_q[i]);
      le = m1 ? edge_hit(c[`GPTU_F_EDGE], state_reg.latch1, state_reg.latch1_q)
              : edge_hit(c[`GPTU_F_EDGE], state_reg.latch2, state_reg.latch2_q);
      // Software direction, pin may invert it
      dnow = c[`GPTU_F_DOWN] ^ (c[`GPTU_F_EXTDIR] & timer_direction_input[i]);
      case (md)
        gptu_pkg::M_TIMER: ev = tick;
        gptu_pkg::M_COUNTER: ev = pe;
        // Gate level qualifies the prescaled clock
        gptu_pkg::M_GATE_HI: ev = tick & timer_count_gate_input[i];
        gptu_pkg::M_GATE_LO: ev = tick & ~timer_count_gate_input[i];
        // Quadrature decode, A on count pin, B on direction pin
        gptu_pkg::M_INCR: begin
          ev = (c[`GPTU_F_EDGE] != 2'h0)
             & ((timer_count_gate_input[i] ^ state_reg.cgi_q[i])
              | (timer_direction_input[i] ^ state_reg.dir_q[i]));
          dnow = ~(timer_count_gate_input[i] ^ state_reg.dir_q[i]);
        end
        // Chaining, cores on their aux wrap
        // Auxiliary timers on toggle latch edges
        gptu_pkg::M_CHAIN: begin
          if (i == `GPTU_CORE) begin
            ev = wrap[`GPTU_AUXA];
          end else if (i == `GPTU_SCORE) begin
            ev = wrap[`GPTU_SAUX];
          end else begin
            ev = le;
          end
        end
        // Capture and reload modes never count
        default: ev = 1'b0;
      endcase
      ev = ev & c[`GPTU_F_RUN];
      // Pending bit holds an event until the next base step
      step[i] = (state_reg.pend[i] | ev) & base;
      dn[i] = ev ? dnow : state_reg.pend_dn[i];
      state_next.pend[i] = (state_reg.pend[i] | ev) & ~base;
      state_next.pend_dn[i] = dn[i];
      if (m1 && i != `GPTU_CORE && md == gptu_pkg::M_CAPTURE && pe) begin
        cap[i] = 1'b1;
        ld[i] = 1'b1;
        ldv[i] = val[`GPTU_CORE];
      end
      // Pin or latch edge reloads the core
      // Opposite latch edges alternate the two values
      if (m1 && i != `GPTU_CORE && md == gptu_pkg::M_RELOAD
          && (c[`GPTU_F_LTRIG] ? le : pe) && !ld[`GPTU_CORE]) begin
        rld[i] = 1'b1;
        ld[`GPTU_CORE] = 1'b1;
        ldv[`GPTU_CORE] = val[i];
      end
    end

    // Second core wrap reloads from capture register
    if (wrap[`GPTU_SCORE] && state_reg.ctrl[`GPTU_SCORE][`GPTU_F_AUXEN]) begin
      ld[`GPTU_SCORE] = 1'b1;
      ldv[`GPTU_SCORE] = state_reg.capreg;
    end

    c = state_reg.ctrl[`GPTU_SAUX];
    cs = gptu_pkg::gptu_csrc_t'(c[`GPTU_F_CSRC]);
    ec = edge_hit(c[`GPTU_F_EDGE], capture_input_pin, state_reg.cap_q);
    et = edge_hit(c[`GPTU_F_EDGE], timer_count_gate_input[`GPTU_CORE],
                  state_reg.cgi_q[`GPTU_CORE]);
    ed = edge_hit(c[`GPTU_F_EDGE], timer_direction_input[`GPTU_CORE],
                  state_reg.dir_q[`GPTU_CORE]);
    case (cs)
      gptu_pkg::CS_PIN: capr = ec;
      gptu_pkg::CS_CNT: capr = et;
      gptu_pkg::CS_DIR: capr = ed;
      gptu_pkg::CS_BOTH: capr = et | ed;
      default: capr = 1'b0;
    endcase
    // Store second aux, clear it if asked
    if (capr) begin
      state_next.capreg = val[`GPTU_SAUX];
      if (c[`GPTU_F_AUXEN]) begin
        ld[`GPTU_SAUX] = 1'b1;
        ldv[`GPTU_SAUX] = '0;
      end
    end

    if (wrap[`GPTU_CORE]) begin
      state_next.latch1 = ~state_reg.latch1;
    end
    state_next.latch1_q = state_reg.latch1;
    state_next.pin1 = state_next.latch1 & state_reg.ctrl[`GPTU_CORE][`GPTU_F_OUTEN];
    // Second core toggle latch and pin
    if (wrap[`GPTU_SCORE]) begin
      state_next.latch2 = ~state_reg.latch2;
    end
    state_next.latch2_q = state_reg.latch2;
    state_next.pin2 = state_next.latch2 & state_reg.ctrl[`GPTU_SCORE][`GPTU_F_OUTEN];
    // Wrap pulse for the external capture unit
    state_next.wrap_p = wrap[`GPTU_SCORE];

    state_next.cgi_q = timer_count_gate_input;
    state_next.dir_q = timer_direction_input;
    state_next.cap_q = capture_input_pin;

    // Software writes win over hardware loads
    if (reg_wr) begin
      for (int i = 0; i < `GPTU_NT; i++) begin
        if (reg_addr == 4'(`GPTU_A_CTRL + i)) begin
          state_next.ctrl[i] = reg_wdata;
        end
        if (reg_addr == 4'(`GPTU_A_VAL + i)) begin
          swld[i] = 1'b1;
          ld[i] = 1'b1;
          ldv[i] = reg_wdata[W-1:0];
        end
      end
      if (reg_addr == 4'(`GPTU_A_CAPREG)) begin
        state_next.capreg = reg_wdata[W-1:0];
      end
      if (reg_addr == 4'(`GPTU_A_FLAGS)) begin
        clr = reg_wdata[`GPTU_NFL-1:0];
      end
    end

    // Flags, a new event beats a clear
    state_next.flags = (state_reg.flags & ~clr) | {capr, cap[`GPTU_AUXB], cap[`GPTU_AUXA], wrap};

    // Read data valid only in the cycle after the strobe
    state_next.rdata = '0;
    if (reg_rd) begin
      for (int i = 0; i < `GPTU_NT; i++) begin
        if (reg_addr == 4'(`GPTU_A_CTRL + i)) begin
          state_next.rdata = state_reg.ctrl[i];
        end
        if (reg_addr == 4'(`GPTU_A_VAL + i)) begin
          state_next.rdata = 16'(val[i]);
        end
      end
      if (reg_addr == 4'(`GPTU_A_CAPREG)) begin
        state_next.rdata = 16'(state_reg.capreg);
      end
      if (reg_addr == 4'(`GPTU_A_FLAGS)) begin
        state_next.rdata = 16'(state_reg.flags);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata = state_reg.rdata;
  assign core_toggle_output_pin = state_reg.pin1;
  assign second_core_toggle_output_pin = state_reg.pin2;
  assign second_core_wrap_pulse = state_reg.wrap_p;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_core_quiet3;
    !step[`GPTU_CORE] [*3];
  endsequence

  a_m1_rate: assert property (step[`GPTU_CORE] |=> s_core_quiet3)
    else $error("core timer stepped faster than every 4 clocks");
  a_m2_rate: assert property (step[`GPTU_SCORE] |=> !step[`GPTU_SCORE])
    else $error("second core stepped faster than every 2 clocks");
  a_latch_toggle: assert property (wrap[`GPTU_CORE] |=> state_reg.latch1 != $past(state_reg.latch1))
    else $error("core latch did not toggle on wrap");
  a_aux_stopped: assert property (
    state_reg.ctrl[`GPTU_AUXA][`GPTU_F_MODE] inside {gptu_pkg::M_RELOAD, gptu_pkg::M_CAPTURE}
    |-> !step[`GPTU_AUXA])
    else $error("auxiliary timer counted while capture or reload");
  a_capture_copy: assert property (cap[`GPTU_AUXB] && !swld[`GPTU_AUXB]
    |=> val[`GPTU_AUXB] == $past(val[`GPTU_CORE]))
    else $error("capture did not copy core value");
  a_core_reload: assert property (rld[`GPTU_AUXA] && !swld[`GPTU_CORE]
    |=> val[`GPTU_CORE] == $past(val[`GPTU_AUXA]))
    else $error("core not reloaded from auxiliary timer");
  a_capreg_store: assert property (capr && !(reg_wr && reg_addr == 4'(`GPTU_A_CAPREG))
    |=> state_reg.capreg == $past(val[`GPTU_SAUX]))
    else $error("capture register missed second aux value");
  a_capreg_clear: assert property (capr && state_reg.ctrl[`GPTU_SAUX][`GPTU_F_AUXEN]
    && !swld[`GPTU_SAUX] |=> val[`GPTU_SAUX] == '0)
    else $error("second aux not cleared after capture");
  a_score_reload: assert property (wrap[`GPTU_SCORE] && state_reg.ctrl[`GPTU_SCORE][`GPTU_F_AUXEN]
    && !swld[`GPTU_SCORE] |=> val[`GPTU_SCORE] == $past(state_reg.capreg))
    else $error("second core not reloaded from capture register");
  a_wrap_pulse: assert property (wrap[`GPTU_SCORE] |=> second_core_wrap_pulse)
    else $error("wrap pulse missing");
  a_flag_set: assert property (wrap[`GPTU_CORE] |=> state_reg.flags[`GPTU_CORE])
    else $error("wrap flag not set");
  a_stopped_idle: assert property (!state_reg.ctrl[`GPTU_CORE][`GPTU_F_RUN]
    && !state_reg.pend[`GPTU_CORE] |-> !step[`GPTU_CORE])
    else $error("core stepped while stopped");
endmodule : gptu_top

// ===== hdl/gptu_map.svh
// Offsets, field positions and counts of the general purpose timer unit
// Included by bare name; registers are 16-bit words on a plain strobe port
`ifndef GPTU_MAP_SVH
`define GPTU_MAP_SVH
// Timer indices
`define GPTU_NT 5
`define GPTU_M1_NT 3
`define GPTU_CORE 0
`define GPTU_AUXA 1
`define GPTU_AUXB 2
`define GPTU_SCORE 3
`define GPTU_SAUX 4
// Register word addresses
`define GPTU_A_CTRL 0
`define GPTU_A_VAL 5
`define GPTU_A_CAPREG 10
`define GPTU_A_FLAGS 11
// Control word fields
`define GPTU_F_MODE 2:0
`define GPTU_F_PRE 5:3
`define GPTU_F_RUN 6
`define GPTU_F_DOWN 7
`define GPTU_F_EXTDIR 8
`define GPTU_F_EDGE 10:9
`define GPTU_F_OUTEN 11
`define GPTU_F_AUXEN 12
`define GPTU_F_CSRC 14:13
`define GPTU_F_LTRIG 15
// Flag bits above the five wrap flags
`define GPTU_FL_CAPA 5
`define GPTU_FL_CAPB 6
`define GPTU_FL_CAPR 7
`define GPTU_NFL 8
// Base resolution as log2 of system clocks
`define GPTU_M1_BASE_LOG 2
`define GPTU_M2_BASE_LOG 1
`endif

// ===== hdl/gptu_pkg.sv
// Types shared by the timer unit modules
// Field positions live in gptu_map.svh
package gptu_pkg;
  typedef enum logic [2:0] {
    M_TIMER,
    M_COUNTER,
    M_GATE_HI,
    M_GATE_LO,
    M_INCR,
    M_RELOAD,
    M_CAPTURE,
    M_CHAIN
  } gptu_mode_t;
  typedef enum logic [1:0] {
    CS_PIN,
    CS_CNT,
    CS_DIR,
    CS_BOTH
  } gptu_csrc_t;
endpackage : gptu_pkg

// ===== hdl/gptu_timer.sv
// One up/down counter slice of the timer unit
// Step, direction and load come from the owning unit each cycle
`timescale 1ns/1ps
module gptu_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Count control
  input wire logic step,
  input wire logic down,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  // Count state
  output logic [W-1:0] value,
  output logic wrap
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } gptu_timer_state_t;
  gptu_timer_state_t state_reg;
  gptu_timer_state_t state_next;
  if (W < 2) begin : g_bad_width
    $error("gptu_timer width too small");
  end
  // Wrap ignores load so a reload on wrap forms no loop
  always_comb begin
    state_next = state_reg;
    wrap = step & (down ? (state_reg.cnt == '0) : (state_reg.cnt == '1));
    if (load) begin
      state_next.cnt = load_val;
    end else if (step) begin
      state_next.cnt = down ? state_reg.cnt - 1'b1 : state_reg.cnt + 1'b1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
  assign value = state_reg.cnt;
  a_wrap_rolls: assert property (@(posedge core_clk) disable iff (!resetn)
    wrap && !load |=> value == ($past(down) ? '1 : '0))
    else $error("counter did not roll over on wrap");
endmodule : gptu_timer

// ===== testbench/gptu_sensor.sv
// Model of the sensors and pulse sources wired to the timer unit pins
// Assumes the unit samples the pins on core_clk; every change lands just after a rising edge
`timescale 1ns/1ps
module gptu_sensor (
  // Clock
  input wire logic core_clk,
  // Pins toward the timer unit
  output logic [4:0] cnt_pin,
  output logic [4:0] dir_pin,
  output logic cap_pin
);
  // Index 0-4 count pins, 5-9 direction pins, 10 capture pin
  logic [10:0] pins = 11'h000;
  int q = 0;
  assign cnt_pin = pins[4:0];
  assign dir_pin = pins[9:5];
  assign cap_pin = pins[10];
  task automatic set_pin(input int i, input logic v);
    @(posedge core_clk);
    pins[i] <= v;
  endtask : set_pin
  // Slow sources are modelled by a longer hold
  task automatic pulse(input int i, input int hold);
    set_pin(i, 1'b1);
    repeat (hold) @(posedge core_clk);
    set_pin(i, 1'b0);
    repeat (hold) @(posedge core_clk);
  endtask : pulse
  // One quadrature step, one line changes; A leads B going forward
  task automatic quad(input int t, input logic fwd);
    q = fwd ? (q + 1) % 4 : (q + 3) % 4;
    @(posedge core_clk);
    pins[t] <= (q == 1 || q == 2);
    pins[t + 5] <= (q >= 2);
    repeat (8) @(posedge core_clk);
  endtask : quad
endmodule : gptu_sensor

// ===== testbench/gptu_top_bench.sv
// Self-checking bench of the timer unit: register port, modes, wraps, capture and reload
// Pins come from gptu_sensor; expected values are worked out here with integers
`timescale 1ns/1ps
module gptu_top_bench;
  localparam logic [15:0] RUN = 16'h0040;
  localparam logic [15:0] DN = 16'h0080;
  localparam logic [15:0] XD = 16'h0100;
  localparam logic [15:0] ER = 16'h0200;
  localparam logic [15:0] EF = 16'h0400;
  localparam logic [15:0] OE = 16'h0800;
  localparam logic [15:0] AX = 16'h1000;
  localparam logic [15:0] LT = 16'h8000;
  logic core_clk;
  logic resetn;
  logic reg_wr;
  logic reg_rd;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic [4:0] cnt_pin;
  logic [4:0] dir_pin;
  logic cap_pin;
  logic out1;
  logic out2;
  logic wpulse;
  logic [15:0] v0;
  logic [15:0] v1;
  logic [15:0] exp_v;
  int err_count = 0;
  int tests_run = 0;
  int seed = 60;
  int pulses = 0;
  int hi_len;

  gptu_top dut (
    .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .timer_count_gate_input(cnt_pin), .timer_direction_input(dir_pin), .capture_input_pin(cap_pin),
    .core_toggle_output_pin(out1), .second_core_toggle_output_pin(out2), .second_core_wrap_pulse(wpulse)
  );
  gptu_sensor sen (.core_clk(core_clk), .cnt_pin(cnt_pin), .dir_pin(dir_pin), .cap_pin(cap_pin));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (wpulse === 1'b1) pulses++;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] expv);
    tests_run++;
    if (seen !== expv) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, expv, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // Two reads taken exactly 64 clocks apart, so the step count is phase free
  task automatic rate(input string what, input int t, input logic [15:0] c, input int dlt);
    wr(4'(t), c);
    rd(4'(t + 5), v0);
    repeat (62) @(posedge core_clk);
    rd(4'(t + 5), v1);
    check(what, v1 - v0, 16'(dlt));
  endtask : rate
  task automatic results;
    if (err_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  initial begin
    repeat (30000) @(posedge core_clk);
    err_count++;
    results();
  end

  initial begin
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    check("pins after reset", {13'h0000, out1, out2, wpulse}, 16'h0000);
    wr(4'hC, 16'hFFFF);
    for (int a = 0; a < 16; a++) begin
      rd(4'(a), v0);
      check("word after reset", v0, 16'h0000);
    end
    for (int t = 0; t < 5; t++) begin
      exp_v = 16'($random(seed));
      wr(4'(t + 5), exp_v);
      rd(4'(t + 5), v0);
      check("timer value", v0, exp_v);
      wr(4'(t + 5), 16'h0000);
    end
    for (int p = 0; p < 3; p++) begin
      rate("first prescale", 0, RUN | 16'(p << 3), 16 >> p);
      rate("second prescale", 3, RUN | 16'(p << 3), 32 >> p);
    end
    rate("soft down", 2, RUN | DN, -16);
    sen.set_pin(6, 1'b1);
    rate("pin down", 1, RUN | XD, -16);
    rate("pin inverts down", 1, RUN | XD | DN, 16);
    sen.set_pin(6, 1'b0);
    for (int e = 1; e < 4; e++) begin
      wr(4'h0, RUN | 16'(e << 9) | 16'h0001);
      rd(4'h5, v0);
      repeat (5) sen.pulse(0, 6);
      rd(4'h5, v1);
      check("counted edges", v1 - v0, 16'(5 * ((e & 1) + (e >> 1))));
    end
    for (int m = 2; m < 4; m++) begin
      for (int g = 0; g < 2; g++) begin
        sen.set_pin(0, g[0]);
        rate("gated", 0, RUN | 16'(m), ((m == 2) == (g == 1)) ? 16 : 0);
      end
    end
    sen.set_pin(0, 1'b0);
    wr(4'h0, RUN | ER | 16'h0004);
    rd(4'h5, v0);
    // Net four steps brings both lines back low for the later pin tests
    repeat (9) sen.quad(0, 1'b1);
    repeat (5) sen.quad(0, 1'b0);
    rd(4'h5, v1);
    check("quadrature", v1 - v0, 16'h0004);
    wr(4'h2, 16'h0000);
    wr(4'h1, RUN | ER | EF | 16'h0007);
    wr(4'h6, 16'h0000);
    wr(4'h0, RUN | OE);
    wr(4'hB, 16'h00FF);
    wr(4'h5, 16'hFFFF);
    repeat (8) @(posedge core_clk);
    check("latch after overflow", {15'h0000, out1}, 16'h0001);
    rd(4'hB, v0);
    check("wrap flag", v0 & 16'h0001, 16'h0001);
    wr(4'hB, 16'h0001);
    rd(4'hB, v0);
    check("wrap flag cleared", v0 & 16'h0001, 16'h0000);
    wr(4'h0, RUN | OE | DN);
    wr(4'h5, 16'h0000);
    repeat (8) @(posedge core_clk);
    check("latch after underflow", {15'h0000, out1}, 16'h0000);
    rd(4'h6, v0);
    check("chained on latch", v0, 16'h0002);
    wr(4'h4, RUN | ER | EF | 16'h0007);
    wr(4'h9, 16'h0000);
    wr(4'hA, 16'h1234);
    wr(4'h3, RUN | OE | AX);
    pulses = 0;
    wr(4'h8, 16'hFFFF);
    repeat (8) @(posedge core_clk);
    check("second latch", {15'h0000, out2}, 16'h0001);
    check("wrap pulses", 16'(pulses), 16'h0001);
    rd(4'h8, v0);
    check("reload on wrap", {15'h0000, (v0 - 16'h1234) < 16'h0010}, 16'h0001);
    rd(4'h9, v0);
    check("second chain", v0, 16'h0001);
    wr(4'h0, 16'h0000);
    exp_v = 16'($random(seed));
    wr(4'h5, exp_v);
    wr(4'h2, RUN | ER | 16'h0006);
    wr(4'hB, 16'h00FF);
    sen.pulse(2, 6);
    rd(4'h7, v0);
    check("captured core", v0, exp_v);
    repeat (40) @(posedge core_clk);
    rd(4'h7, v0);
    check("capture holds", v0, exp_v);
    rd(4'hB, v0);
    check("capture flag", v0 & 16'h0040, 16'h0040);
    exp_v = 16'($random(seed));
    wr(4'h6, exp_v);
    wr(4'h1, RUN | ER | 16'h0005);
    sen.pulse(1, 6);
    rd(4'h5, v0);
    check("pin reload", v0, exp_v);
    // Alternate reloads: high 16 steps, low 32 steps, period 192 clocks
    wr(4'h6, 16'hFFF0);
    wr(4'h7, 16'hFFE0);
    wr(4'h1, RUN | ER | LT | 16'h0005);
    wr(4'h2, RUN | EF | LT | 16'h0005);
    wr(4'h0, RUN | OE);
    wr(4'h5, 16'hFFFF);
    repeat (60) @(posedge core_clk);
    hi_len = 0;
    repeat (384) begin
      @(posedge core_clk);
      if (out1 === 1'b1) hi_len++;
    end
    check("pwm high time", {15'h0000, hi_len >= 120 && hi_len <= 136}, 16'h0001);
    wr(4'h0, 16'h0000);
    for (int s = 0; s < 4; s++) begin
      exp_v = 16'($random(seed));
      wr(4'h9, exp_v);
      wr(4'h4, RUN | ER | AX | 16'(s << 13) | 16'h0001);
      wr(4'hB, 16'h00FF);
      sen.pulse(s == 0 ? 10 : (s == 2 ? 5 : 0), 6);
      rd(4'hA, v0);
      check("capture register", v0, exp_v);
      rd(4'h9, v0);
      check("cleared after capture", v0, 16'h0000);
      rd(4'hB, v0);
      check("capture register flag", v0 & 16'h0080, 16'h0080);
    end
    // Mid-run reset with latches, flags and capture register all set
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    check("pins after mid-run reset", {13'h0000, out1, out2, wpulse}, 16'h0000);
    for (int a = 0; a < 16; a++) begin
      rd(4'(a), v0);
      check("word after mid-run reset", v0, 16'h0000);
    end
    results();
  end
endmodule : gptu_top_bench
